// ==== fspc_pkg.sv ====
// Package: opcodes, frame lengths, status layout, timing and carrier types
package fspc_pkg;
  // Opcodes decoded by the interpreter
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OPC_STATUS_READ      = 8'h05;
  localparam logic [7:0] OPC_OTP_REGION_READ  = 8'h4B;
  localparam logic [7:0] OPC_PROT_CFG_READ    = 8'h2B;
  localparam logic [7:0] OPC_PROT_CFG_PROGRAM = 8'h2F;
  localparam logic [7:0] OPC_VOL_LOCK_READ    = 8'hE0;
  localparam logic [7:0] OPC_VOL_LOCK_WRITE   = 8'hE1;
  localparam logic [7:0] OPC_PER_LOCK_READ    = 8'hE2;
  localparam logic [7:0] OPC_PER_LOCK_PROGRAM = 8'hE3;
  localparam logic [7:0] OPC_PER_LOCK_ERASE   = 8'hE4;
  localparam logic [7:0] OPC_LOCK_FREEZE_READ = 8'hA7;
  // Frame lengths in serial clocks, counted from chip select low
  localparam logic [5:0] LEN_OPC       = 6'h08;
  localparam logic [5:0] LEN_OTP_ADDR  = 6'h20; // opcode plus 24 address bits
  localparam logic [5:0] LEN_OTP_DUMMY = 6'h28; // plus one dummy byte
  localparam logic [5:0] LEN_SECT_ADDR = 6'h28; // opcode plus 32 address bits
  localparam logic [5:0] LEN_CFG_PROG  = 6'h18; // opcode plus two data bytes
  localparam logic [5:0] LEN_VOL_WRITE = 6'h30; // opcode, address, one byte
  localparam logic [5:0] LEN_MAX       = 6'h3F;
  // OTP region geometry
  localparam int OTP_AW = 10; // 1024 bytes
  // Sector geometry: 256 KiB sectors
  localparam int SECT_LSB = 18;
  // Status byte layout
  localparam int ST_WIP  = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_PERR = 6;
  // Reset values
  localparam logic [15:0] PROT_CFG_RST    = 16'hFFFF;
  localparam logic [7:0]  LOCK_FREEZE_RST = 8'h01;
  localparam int          FRZ_BIT         = 0;
  // Self-timed operation times and clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_NS  = 340000;
  localparam int ERASE_TIME_NS = 520000000;
  localparam int PROG_CYCLES_DEF  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Serial pins travel together
  typedef struct packed
  {
    logic cs_n;
    logic sck;
    logic si;
  } fspc_pins_t;
  // Kinds of self-timed work
  typedef enum logic [1:0] {K_CFG, K_VOL, K_PER, K_ERASE} fspc_kind_t;
endpackage

// ==== fspc_top.sv ====
// Serial flash sector protection command interpreter
`timescale 1ns/1ps
module fspc_top
  import fspc_pkg::*;
#(
  parameter int SECT_W       = 8,                 // Sector index width
  parameter int PROG_CYCLES  = PROG_CYCLES_DEF,   // Program cycle length
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF   // Erase phase length
)
(
  input  wire logic              clock,           // System clock
  input  wire logic              nrst,            // Async reset, active low
  input  wire fspc_pins_t        pins,            // Chip select, serial clock, serial in
  input  wire logic [7:0]        otp_data,        // OTP byte at otp_addr
  input  wire logic              prog_fail,       // Array reports failed program
  input  wire logic              suspend_req,     // Erase suspend request pulse
  output logic                   so_out,          // Serial output level
  output logic                   so_oe,           // Serial output enable
  output logic [OTP_AW:0]        otp_addr,        // OTP byte address
  output logic                   write_in_progress, // Self-timed op running
  output logic                   write_enable_latch, // Writes enabled
  output logic                   program_error,   // Last program failed
  output logic                   suspend_refused  // Suspend refused pulse
);
  localparam int NSECT = 1 << SECT_W;

  // Synchronisers and edge detect
  fspc_pins_t        meta_ff;
  fspc_pins_t        sync_ff;
  fspc_pins_t        last_ff;
  logic              rise;
  logic              fall;
  logic              cs_up;
  logic              act;

  // Frame state
  logic [39:0]       sr_ff;
  logic [39:0]       nxt_sr;
  logic [5:0]        cnt_ff;
  logic [7:0]        opc_ff;
  logic [15:0]       tx_ff;
  logic [2:0]        bit_ff;
  logic              rd_ff;
  logic              otp_ff;
  logic              so_ff;
  logic              oe_ff;
  logic [OTP_AW:0]   oaddr_ff;

  // Command hand-off to the engine
  logic              write_enable_cmd_ff;
  logic              start_ff;
  fspc_kind_t        kind_ff;
  logic [15:0]       pcfg_ff;
  logic [SECT_W-1:0] psect_ff;
  logic              pbit_ff;

  // Engine and stored state
  typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_PREPROG, OP_ERASE} fspc_op_t;
  fspc_op_t          op_ff;
  int                tmr_ff;
  logic              wip_ff;
  logic              wel_ff;
  logic              perr_ff;
  logic              srf_ff;
  logic [15:0]       cfg_ff;
  logic [7:0]        frz_ff;
  logic [NSECT-1:0]  vlock_ff;
  logic [NSECT-1:0]  plock_ff;

  // Sector index out of a 32-bit address
  function automatic logic [SECT_W-1:0] sect_of(input logic [31:0] a);
    sect_of = a[SECT_LSB +: SECT_W];
  endfunction

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      sync_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      last_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    end
    else
    begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Serial clock edges only count inside a frame
  assign act    = !sync_ff.cs_n;
  assign rise   = act && sync_ff.sck && !last_ff.sck;
  assign fall   = act && !sync_ff.sck && last_ff.sck;
  assign cs_up  = sync_ff.cs_n && !last_ff.cs_n;
  assign nxt_sr = {sr_ff[38:0], sync_ff.si};

  // Frame shifter, opcode decode and serial output
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sr_ff    <= '0;
      cnt_ff   <= '0;
      opc_ff   <= '0;
      tx_ff    <= '0;
      bit_ff   <= '0;
      rd_ff    <= 1'b0;
      otp_ff   <= 1'b0;
      so_ff    <= 1'b0;
      oe_ff    <= 1'b0;
      oaddr_ff <= '0;
    end
    else if (!act)
    begin
      cnt_ff <= '0;
      rd_ff  <= 1'b0;
      otp_ff <= 1'b0;
      oe_ff  <= 1'b0;
      bit_ff <= '0;
    end
    else if (rise)
    begin
      sr_ff <= nxt_sr;
      if (cnt_ff != LEN_MAX)
        cnt_ff <= cnt_ff + 6'h01;
      if (cnt_ff == LEN_OPC - 6'h01)
      begin
        opc_ff <= nxt_sr[7:0];
        if (wip_ff && nxt_sr[7:0] != OPC_STATUS_READ)
          rd_ff <= 1'b0;
        else if (nxt_sr[7:0] == OPC_PROT_CFG_READ)
        begin
          tx_ff <= {cfg_ff[7:0], cfg_ff[15:8]};
          rd_ff <= 1'b1;
        end
        else if (nxt_sr[7:0] == OPC_STATUS_READ)
        begin
          tx_ff <= {2{1'b0, perr_ff, 4'h0, wel_ff, wip_ff}};
          rd_ff <= 1'b1;
        end
        else if (nxt_sr[7:0] == OPC_LOCK_FREEZE_READ)
        begin
          tx_ff <= {frz_ff, frz_ff};
          rd_ff <= 1'b1;
        end
      end
      if (cnt_ff == LEN_OTP_ADDR - 6'h01 && opc_ff == OPC_OTP_REGION_READ && !wip_ff)
        oaddr_ff <= {1'b0, nxt_sr[OTP_AW-1:0]};
      if (cnt_ff == LEN_OTP_DUMMY - 6'h01 && opc_ff == OPC_OTP_REGION_READ && !wip_ff)
      begin
        tx_ff    <= {otp_data, otp_data};
        oaddr_ff <= oaddr_ff + 1'b1;
        rd_ff    <= 1'b1;
        otp_ff   <= 1'b1;
      end
      if (cnt_ff == LEN_SECT_ADDR - 6'h01 && !wip_ff)
      begin
        if (opc_ff == OPC_VOL_LOCK_READ)
        begin
          tx_ff <= {16{vlock_ff[sect_of(nxt_sr[31:0])]}};
          rd_ff <= 1'b1;
        end
        else if (opc_ff == OPC_PER_LOCK_READ)
        begin
          tx_ff <= {16{plock_ff[sect_of(nxt_sr[31:0])]}};
          rd_ff <= 1'b1;
        end
      end
    end
    else if (fall && rd_ff)
    begin
      so_ff  <= tx_ff[15];
      oe_ff  <= 1'b1;
      tx_ff  <= {tx_ff[14:0], tx_ff[15]};
      bit_ff <= bit_ff + 3'h1;
      // address stops one past top, no wrap
      if (otp_ff && bit_ff == 3'h7)
      begin
        tx_ff    <= {otp_data, otp_data};
        oaddr_ff <= (oaddr_ff[OTP_AW]) ? oaddr_ff : oaddr_ff + 1'b1;
      end
    end
  end

  // End of frame: check length and latch, then hand off
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      write_enable_cmd_ff  <= 1'b0;
      start_ff <= 1'b0;
      kind_ff  <= K_CFG;
      pcfg_ff  <= '0;
      psect_ff <= '0;
      pbit_ff  <= 1'b0;
    end
    else
    begin
      write_enable_cmd_ff  <= 1'b0;
      start_ff <= 1'b0;
      // wrong length or latch: no change
      if (cs_up && !wip_ff)
      begin
        if (cnt_ff == LEN_OPC && sr_ff[7:0] == OPC_WRITE_ENABLE_CMD)
          write_enable_cmd_ff <= 1'b1;
        if (wel_ff)
        begin
          if (cnt_ff == LEN_CFG_PROG && opc_ff == OPC_PROT_CFG_PROGRAM)
          begin
            start_ff <= 1'b1;
            kind_ff  <= K_CFG;
            pcfg_ff  <= {sr_ff[7:0], sr_ff[15:8]};
          end
          if (cnt_ff == LEN_VOL_WRITE && opc_ff == OPC_VOL_LOCK_WRITE)
          begin
            start_ff <= 1'b1;
            kind_ff  <= K_VOL;
            psect_ff <= sect_of(sr_ff[39:8]);
            pbit_ff  <= sr_ff[7:0] == 8'hFF;
          end
          if (cnt_ff == LEN_SECT_ADDR && opc_ff == OPC_PER_LOCK_PROGRAM)
          begin
            start_ff <= 1'b1;
            kind_ff  <= K_PER;
            psect_ff <= sect_of(sr_ff[31:0]);
          end
          if (cnt_ff == LEN_OPC && sr_ff[7:0] == OPC_PER_LOCK_ERASE)
          begin
            start_ff <= 1'b1;
            kind_ff  <= K_ERASE;
          end
        end
      end
    end
  end

  // Self-timed engine, flags and stored locks
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      op_ff    <= OP_IDLE;
      tmr_ff   <= 0;
      wip_ff   <= 1'b0;
      wel_ff   <= 1'b0;
      perr_ff  <= 1'b0;
      cfg_ff   <= PROT_CFG_RST;
      frz_ff   <= LOCK_FREEZE_RST;
      vlock_ff <= '1;
      plock_ff <= '1;
    end
    else
    begin
      if (write_enable_cmd_ff)
        wel_ff <= 1'b1;
      unique case (op_ff)
        OP_IDLE:
        begin
          if (start_ff)
          begin
            wip_ff  <= 1'b1;
            perr_ff <= 1'b0;
            tmr_ff  <= PROG_CYCLES - 1;
            op_ff   <= (kind_ff == K_ERASE) ? OP_PREPROG : OP_PROG;
          end
        end
        OP_PROG:
        begin
          if (tmr_ff != 0)
            tmr_ff <= tmr_ff - 1;
          else
          begin
            // failed program leaves data, sets error
            if (prog_fail || (kind_ff == K_PER && !frz_ff[FRZ_BIT]))
              perr_ff <= 1'b1;
            else if (kind_ff == K_CFG)
              cfg_ff <= pcfg_ff;
            else if (kind_ff == K_VOL)
              vlock_ff[psect_ff] <= pbit_ff;
            else
              plock_ff[psect_ff] <= 1'b0;
            wip_ff <= 1'b0;
            wel_ff <= 1'b0;
            op_ff  <= OP_IDLE;
          end
        end
        OP_PREPROG:
        begin
          if (tmr_ff != 0)
            tmr_ff <= tmr_ff - 1;
          else
          begin
            plock_ff <= '0;
            tmr_ff   <= ERASE_CYCLES - 1;
            op_ff    <= OP_ERASE;
          end
        end
        OP_ERASE:
        begin
          if (tmr_ff != 0)
            tmr_ff <= tmr_ff - 1;
          else
          begin
            plock_ff <= '1;
            wip_ff   <= 1'b0;
            wel_ff   <= 1'b0;
            op_ff    <= OP_IDLE;
          end
        end
      endcase
    end
  end

  // Suspend answer; no suspend during the lock erase
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      srf_ff <= 1'b0;
    else
      srf_ff <= suspend_req && (op_ff == OP_PREPROG || op_ff == OP_ERASE);
  end

  assign so_out             = so_ff;
  assign so_oe              = oe_ff;
  assign otp_addr           = oaddr_ff;
  assign write_in_progress  = wip_ff;
  assign write_enable_latch = wel_ff;
  assign program_error      = perr_ff;
  assign suspend_refused    = srf_ff;

  // Checks
  wip_start_a: assert property (@(posedge clock) disable iff (!nrst)
    start_ff && op_ff == OP_IDLE |=> wip_ff) else $error("op start without busy flag");
  wel_done_a: assert property (@(posedge clock) disable iff (!nrst)
    $fell(wip_ff) |-> !wel_ff) else $error("latch still set after op");
  wel_need_a: assert property (@(posedge clock) disable iff (!nrst)
    start_ff |-> $past(wel_ff)) else $error("write started without latch");
  erase_len_a: assert property (@(posedge clock) disable iff (!nrst)
    start_ff && kind_ff == K_ERASE |-> $past(cnt_ff) == LEN_OPC) else $error("bad erase length");
  erase_ones_a: assert property (@(posedge clock) disable iff (!nrst)
    op_ff == OP_ERASE ##1 op_ff == OP_IDLE |-> plock_ff == '1) else $error("locks not erased");
  susp_ref_a: assert property (@(posedge clock) disable iff (!nrst)
    suspend_req && (op_ff == OP_PREPROG || op_ff == OP_ERASE) |=> suspend_refused)
    else $error("suspend not refused");
  busy_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
    rise && cnt_ff == 6'h07 && wip_ff && nxt_sr[7:0] != OPC_STATUS_READ |=> !rd_ff)
    else $error("command answered while busy");
  cfg_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    op_ff == OP_IDLE && !start_ff |=> $stable(cfg_ff)) else $error("config changed when idle");
endmodule

// ==== fspc_host_model.sv ====
// SPI host model that frames commands onto the flash pins
`timescale 1ns/1ps
module fspc_host_model
  import fspc_pkg::*;
(
  input  wire logic   clock,   // System clock
  input  wire logic   so_out,  // Device serial output
  input  wire logic   so_oe,   // Device output enable
  output fspc_pins_t  pins,    // Chip select, serial clock, serial in
  output logic        rd_done, // Pulse after a read frame
  output logic [63:0] rx_data, // Read bits, last bit in bit 0
  output logic        oe_seen  // Device drove SO during the frame
);
  initial
  begin
    pins = '{1'b1, 1'b0, 1'b1};
    rd_done = 1'b0;
    rx_data = '0;
    oe_seen = 1'b0;
  end
  task automatic frame(input logic [63:0] tx, input int ncmd, input int nrd);
    int i;
    @(posedge clock);
    pins.cs_n <= 1'b0;
    oe_seen <= 1'b0;
    rx_data <= '0;
    repeat (4) @(posedge clock);
    for (i = 0; i < ncmd + nrd; i++)
    begin
      pins.sck <= 1'b0;
      pins.si <= (i < ncmd) ? tx[ncmd-1-i] : 1'b0;
      repeat (4) @(posedge clock);
      pins.sck <= 1'b1;
      repeat (4) @(posedge clock);
      // Sampled late in the high phase, well after the device's fall update
      if (i >= ncmd)
        rx_data <= {rx_data[62:0], so_out};
    end
    pins.sck <= 1'b0;
    repeat (4) @(posedge clock);
    pins.cs_n <= 1'b1;
    // Released SI shows the inverse so a stale bit is never trusted
    pins.si <= ~pins.si;
    rd_done <= (nrd > 0);
    @(posedge clock);
    rd_done <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // Output enable watch across the frame
  always @(posedge clock)
    if (!pins.cs_n && so_oe)
      oe_seen <= 1'b1;
endmodule

// ==== flash_sector_protection_cmds_bench.sv ====
// Self-checking bench for the sector protection command interpreter
`timescale 1ns/1ps
module flash_sector_protection_cmds_bench;
  import fspc_pkg::*;
  localparam int PC = 600; // Long enough to poll status and try A7h while busy
  localparam int EC = 30;
  logic        clock;
  logic        nrst;
  fspc_pins_t  pins;
  logic [7:0]  otp_data;
  logic        prog_fail;
  logic        suspend_req;
  logic        so_out;
  logic        so_oe;
  logic [10:0] otp_addr;
  logic        write_in_progress;
  logic        write_enable_latch;
  logic        program_error;
  logic        suspend_refused;
  logic        rd_done;
  logic [63:0] rx_data;
  logic        oe_seen;
  logic [63:0] expq[$];
  logic [63:0] exp_v;
  logic [31:0] r;
  logic [31:0] sa;
  logic [31:0] na;
  logic [7:0]  lo;
  logic [7:0]  hi;
  integer      seed;
  int          bad_count;
  int          checks;
  // OTP contents seen by the design
  assign otp_data = otp_addr[7:0] ^ 8'h5A;
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  fspc_top #(.SECT_W(8), .PROG_CYCLES(PC), .ERASE_CYCLES(EC)) DUT (
    .clock(clock), .nrst(nrst), .pins(pins), .otp_data(otp_data),
    .prog_fail(prog_fail), .suspend_req(suspend_req), .so_out(so_out),
    .so_oe(so_oe), .otp_addr(otp_addr), .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch), .program_error(program_error),
    .suspend_refused(suspend_refused));
  fspc_host_model host (
    .clock(clock), .so_out(so_out), .so_oe(so_oe), .pins(pins),
    .rd_done(rd_done), .rx_data(rx_data), .oe_seen(oe_seen));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Note the expectation, then run the frame
  task automatic rd(input logic [63:0] tx, input int nc, input int nr, input logic [63:0] e);
    expq.push_back(e);
    host.frame(tx, nc, nr);
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 2000 && write_in_progress !== 1'b0; n++)
      @(posedge clock);
    check("idle", write_in_progress, 1'b0);
  endtask
  task automatic write_enable_cmd();
    host.frame(64'h06, 8, 0);
  endtask
  // Read results compared in arrival order
  always @(posedge clock)
    if (rd_done === 1'b1)
    begin
      exp_v = expq.pop_front();
      check("read data", rx_data, exp_v);
    end
  // Watchdog sized well above the whole sequence
  initial
  begin
    repeat (60000) @(posedge clock);
    bad_count++;
    stop_test();
  end
  initial
  begin
    seed = 32'h03A5C6A1;
    nrst = 1'b0;
    prog_fail = 1'b0;
    suspend_req = 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    check("wip", write_in_progress, 1'b0);
    check("wel", write_enable_latch, 1'b0);
    // Suspend outside the lock erase is not refused
    suspend_req <= 1'b1;
    @(posedge clock);
    suspend_req <= 1'b0;
    #1;
    check("refused idle", suspend_refused, 1'b0);
    r = $random(seed);
    lo = r[7:0];
    hi = r[15:8];
    sa = {6'h00, 1'b0, r[22:16], 18'h0};
    na = sa + 32'h0004_0000;
    rd(64'h05, 8, 8, 64'h00);
    host.frame({40'h0, 8'h2F, lo, hi}, 24, 0);
    check("wip", write_in_progress, 1'b0);
    write_enable_cmd();
    check("wel", write_enable_latch, 1'b1);
    host.frame({41'h0, 8'h2F, lo, hi[7:1]}, 23, 0);
    check("wip", write_in_progress, 1'b0);
    check("wel", write_enable_latch, 1'b1);
    host.frame({40'h0, 8'h2F, lo, hi}, 24, 0);
    check("wip", write_in_progress, 1'b1);
    rd(64'h05, 8, 8, 64'h03);
    host.frame(64'hA70000, 24, 0);
    check("so_oe busy", oe_seen, 1'b0);
    wait_idle();
    check("wel", write_enable_latch, 1'b0);
    check("perr", program_error, 1'b0);
    rd(64'h2B, 8, 32, {32'h0, lo, hi, lo, hi});
    check("so_oe read", oe_seen, 1'b1);
    rd({24'h0, 8'hE0, sa}, 40, 16, 64'hFFFF);
    write_enable_cmd();
    host.frame({16'h0, 8'hE1, sa, 8'h00}, 48, 0);
    wait_idle();
    rd({24'h0, 8'hE0, sa}, 40, 16, 64'h0000);
    rd({24'h0, 8'hE0, na}, 40, 8, 64'hFF);
    write_enable_cmd();
    host.frame({24'h0, 8'hE3, sa}, 40, 0);
    wait_idle();
    rd({24'h0, 8'hE2, sa}, 40, 16, 64'h0000);
    rd({24'h0, 8'hE2, na}, 40, 8, 64'hFF);
    prog_fail <= 1'b1;
    write_enable_cmd();
    host.frame({24'h0, 8'hE3, na}, 40, 0);
    wait_idle();
    check("perr", program_error, 1'b1);
    prog_fail <= 1'b0;
    write_enable_cmd();
    host.frame(64'hE400, 16, 0);
    check("wip", write_in_progress, 1'b0);
    host.frame(64'hE4, 8, 0);
    check("wip", write_in_progress, 1'b1);
    suspend_req <= 1'b1;
    @(posedge clock);
    suspend_req <= 1'b0;
    #1;
    check("refused", suspend_refused, 1'b1);
    wait_idle();
    rd({24'h0, 8'hE2, sa}, 40, 8, 64'hFF);
    rd(64'hA7, 8, 16, 64'h0101);
    rd({24'h0, 8'h4B, 24'h0003FE, 8'h00}, 40, 16, 64'hA4A5);
    check("otp addr", otp_addr, 11'h400);
    // Mid-run reset brings config and address back
    nrst <= 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    check("otp addr reset", otp_addr, 11'h000);
    rd(64'h2B, 8, 16, 64'hFFFF);
    stop_test();
  end
endmodule
